// File: fmt_checker.sv
`default_nettype none
module fmt_checker #(
   parameter int LANES = 8
) (
   input wire logic             core_clk,
   input wire logic             rst,
   input wire logic             ce,
   input wire logic             serial_io_output_mode_pin,
   input wire fmt_pkg::cfg_t    cfg,
   input wire logic             reg_wr_en,
   input wire logic [7:0]       reg_addr,
   input wire logic [7:0]       reg_wdata,
   input wire logic [7:0]       reg_rdata,
   input wire logic [LANES-1:0] data_lanes_out,
   input wire logic             data_bit_clock_out,
   input wire logic             frame_clock_out,
   input wire logic             reduced_swing_out,
   input wire logic             clk_drive_double_out
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   logic          live_r, live_nxt; // one cycle clear of reset
   logic [3:0]    hi_r, hi_nxt;     // frame-high run length
   logic [3:0]    age_r, age_nxt;   // cycles of unchanged config
   fmt_pkg::cfg_t cfg_r, cfg_nxt;   // config of last cycle
   logic [3:0]    half;             // frame-high length for word size

   // next values of helper counters
   always_comb begin
      live_nxt = !rst;
      hi_nxt   = frame_clock_out ? hi_r + 4'h1 : 4'h0;
      cfg_nxt  = cfg;
      age_nxt  = (rst || cfg != cfg_r) ? 4'h0 : age_r + {3'h0, age_r != 4'hf};
      case (cfg.word_len)
         fmt_pkg::WL_8:  half = 4'h4;
         fmt_pkg::WL_10: half = 4'h5;
         fmt_pkg::WL_14: half = 4'h7;
         default:        half = 4'h6;
      endcase
   end

   // helper registers
   always_ff @(posedge core_clk) begin
      live_r <= live_nxt;
      hi_r   <= hi_nxt;
      cfg_r  <= cfg_nxt;
      age_r  <= age_nxt;
   end

   sequence s_twelve_bits;
      $changed(data_bit_clock_out) [*6] ##1 $changed(data_bit_clock_out) [*6];
   endsequence
   sequence s_eight_bits;
      $changed(data_bit_clock_out) [*8];
   endsequence
   sequence s_word_over;
      $rose(frame_clock_out) || (!data_bit_clock_out && !frame_clock_out);
   endsequence

   a_reset_clear: assert property (disable iff (1'b0)
      rst |=> !data_bit_clock_out && !frame_clock_out && data_lanes_out == '0)
      else $error("outputs not clear after reset");
   a_word_twelve: assert property (
      $rose(frame_clock_out) && age_r == 4'hf && cfg.word_len == fmt_pkg::WL_12
      |-> s_twelve_bits ##1 s_word_over) else $error("twelve-bit word malformed");
   a_word_eight: assert property (
      $rose(frame_clock_out) && age_r == 4'hf && cfg.word_len == fmt_pkg::WL_8
      |-> s_eight_bits ##1 s_word_over) else $error("eight-bit word malformed");
   a_frame_half: assert property (
      $fell(frame_clock_out) && age_r == 4'hf |-> hi_r == half)
      else $error("frame high time wrong");
   a_idle_quiet: assert property (
      !data_bit_clock_out && !$changed(data_bit_clock_out)
      |-> data_lanes_out == '0 && !frame_clock_out) else $error("idle lanes busy");
   a_swing_pin: assert property (
      (live_r && ce && serial_io_output_mode_pin) [*4] |=> reduced_swing_out)
      else $error("pin did not reduce swing");
   a_swing_cfg: assert property (
      live_r && ce && cfg.low_swing |=> reduced_swing_out)
      else $error("config did not reduce swing");
   a_drive_double: assert property (
      live_r && ce |=> clk_drive_double_out == $past(cfg.clk_drive_double && cfg.term_sel == 2'h0))
      else $error("clock drive doubling wrong");
   a_reg_readback: assert property (
      live_r && ce && reg_wr_en && reg_addr inside {[8'h19:8'h1c]} ##1 ce && $stable(reg_addr)
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("register readback wrong");
   a_unmapped_zero: assert property (
      live_r && ce && !(reg_addr inside {[8'h19:8'h1c]}) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_lanes_same: assert property (
      age_r == 4'hf && cfg.test_mode inside {[4'h1:4'hc]}
      |-> data_lanes_out == '0 || data_lanes_out == '1) else $error("lanes differ in test mode");
endmodule

bind serial_adc_output_formatter fmt_checker #(.LANES(LANES)) u_fmt_checker (.*);
`default_nettype wire

// File: fmt_pkg.sv
`default_nettype none
package fmt_pkg;
   localparam int LANES       = 8;  // converter channels, one lane each
   localparam int SAMPLE_BITS = 12; // converter resolution
   localparam int WORD_MAX    = 14; // widest serial word
   localparam int CNT_W       = 4;  // bit counter width

   // test-mode selector codes
   typedef enum logic [3:0] {
      TM_OFF      = 4'h0,
      TM_MID      = 4'h1,
      TM_POS      = 4'h2,
      TM_NEG      = 4'h3,
      TM_CHECK    = 4'h4,
      TM_PN_LONG  = 4'h5,
      TM_PN_SHORT = 4'h6,
      TM_WORD_TOG = 4'h7,
      TM_USER     = 4'h8,
      TM_BIT_TOG  = 4'h9,
      TM_SYNC     = 4'ha,
      TM_ONE_HIGH = 4'hb,
      TM_MIXED    = 4'hc
   } test_mode_t;

   // word length selector codes
   localparam logic [1:0] WL_12 = 2'h0;
   localparam logic [1:0] WL_8  = 2'h1;
   localparam logic [1:0] WL_10 = 2'h2;
   localparam logic [1:0] WL_14 = 2'h3;

   // register offsets and reset value
   localparam logic [7:0] REG_USER_ONE_LOW  = 8'h19;
   localparam logic [7:0] REG_USER_ONE_HIGH = 8'h1a;
   localparam logic [7:0] REG_USER_TWO_LOW  = 8'h1b;
   localparam logic [7:0] REG_USER_TWO_HIGH = 8'h1c;
   localparam logic [7:0] REG_RESET         = 8'h00;

   // pseudorandom generator seeds
   localparam logic [8:0]  PN_SHORT_SEED = 9'h0df;
   localparam logic [22:0] PN_LONG_SEED  = 23'h29b80a;

   // mixed-frequency words, right aligned
   localparam logic [13:0] MIX_8  = 14'h00a3;
   localparam logic [13:0] MIX_10 = 14'h0263;
   localparam logic [13:0] MIX_12 = 14'h0a33;
   localparam logic [13:0] MIX_14 = 14'h2867;

   // static configuration from on-chip logic
   typedef struct packed {
      test_mode_t test_mode;        // pattern selector
      logic       twos_comp;        // data format select
      logic       lsb_first;        // serial bit order
      logic [1:0] word_len;         // serial word length code
      logic       low_swing;        // reduced-swing request
      logic       clk_drive_double; // double clock-output drive
      logic [1:0] term_sel;         // output termination control
      logic       low_rate_pll;     // retune for slow sample clocks
   } cfg_t;

   // one converter sample per channel
   typedef struct packed {
      logic [LANES-1:0][SAMPLE_BITS-1:0] ch;
   } samples_t;
endpackage
`default_nettype wire

// File: fmt_receiver.sv
`default_nettype none
module fmt_receiver (
   input  wire logic             core_clk,
   input  wire logic             run,
   input  wire logic [3:0]       len,
   input  wire logic [7:0]       lanes,
   input  wire logic             bclk,
   input  wire logic             fclk,
   output var  logic             sample_pin,
   output var  logic [7:0][13:0] word,
   output var  logic [7:0][13:0] prev,
   output var  int               words
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0][13:0] sh; // per-lane shift registers
   logic             bq; // bit clock last cycle
   logic             fq; // frame clock last cycle
   int               n;  // bits of current word

   // sample clock, 800 ns, still while not asked for
   initial begin
      sample_pin = 1'b0;
      #137;
      forever begin
         sample_pin = run;
         #400 sample_pin = 1'b0;
         #400;
      end
   end

   // one bit per bit-clock edge, rising and falling alike
   initial begin
      {sh, word, prev, bq, fq} = '0;
      {n, words} = '0;
      forever begin
         @(posedge core_clk);
         if (bclk !== bq) begin
            if (fclk && !fq) begin // frame rise opens a word
               n = 0;
               sh = '0;
            end
            for (int i = 0; i < 8; i++) begin
               sh[i] = {sh[i][12:0], lanes[i]};
            end
            n++;
            if (n == int'(len)) begin
               prev = word;
               word = sh;
               words++;
            end
         end
         bq = bclk;
         fq = fclk;
      end
   end
endmodule
`default_nettype wire

// File: pn_bit_source.sv
`default_nettype none
module pn_bit_source (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic step,
   input  wire logic long_sel,
   input  wire logic reseed,
   output var  logic pn_bit
);
   logic [8:0]  short_r;  // 9-stage generator
   logic [8:0]  short_nxt;
   logic [22:0] long_r;   // 23-stage generator
   logic [22:0] long_nxt;

   // advance one bit per serial bit; reload seeds while reseed is high
   always_comb begin
      short_nxt = short_r;
      long_nxt  = long_r;
      if (reseed) begin
         short_nxt = fmt_pkg::PN_SHORT_SEED;
         long_nxt  = fmt_pkg::PN_LONG_SEED;
      end else if (step) begin
         short_nxt = {short_r[7:0], short_r[8] ^ short_r[4]};
         long_nxt  = {long_r[21:0], long_r[22] ^ long_r[17]};
      end
      // long stream is inverted
      pn_bit = long_sel ? ~long_r[22] : short_r[8];
   end

   // state registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         short_r <= fmt_pkg::PN_SHORT_SEED;
         long_r  <= fmt_pkg::PN_LONG_SEED;
      end else if (ce) begin
         short_r <= short_nxt;
         long_r  <= long_nxt;
      end
   end
endmodule
`default_nettype wire

// File: serial_adc_output_formatter.sv
// How it works
// - lvds by default, reduced swing on pin/config
// - clock drive doubling, termination bits override it
// - offset binary default, twos complement selectable
// - offset binary codes, bit 11 most significant
// - one lane per channel, twelve bits per sample
// - config option retunes pll for slow rates
// - bit clock six times sample, ddr data
// - frame clock marks each word start
// - selector zero passes converter data
// - midscale, ones, zeros words follow format
// - checkerboard alternates with its complement
// - ones word alternates with zeros word
// - user words alternate from register pairs
// - bit toggle and one-bit-high words repeat
// - sync and mixed-frequency words repeat
// - short pseudorandom 511 bits, seed 0x0df
// - long pseudorandom, seed 0x29b80a, inverted
// - msb first default, lsb first optional
// - 14-bit adds two zeros; 8/10 shorten
`default_nettype none
module serial_adc_output_formatter #(
   parameter int LANES = fmt_pkg::LANES
) (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              sample_clk_pin,
   input  wire logic              serial_io_output_mode_pin,
   input  wire fmt_pkg::cfg_t     cfg,
   input  wire fmt_pkg::samples_t samples,
   input  wire logic              reg_wr_en,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   output var  logic [7:0]        reg_rdata,
   output var  logic [LANES-1:0]  data_lanes_out,
   output var  logic              data_bit_clock_out,
   output var  logic              frame_clock_out,
   output var  logic              reduced_swing_out,
   output var  logic              clk_drive_double_out,
   output var  logic              pll_low_rate_out
);
   // lane count must match the sample carrier
   if (LANES != fmt_pkg::LANES) begin : g_check
      $error("lane count must equal the channel count");
   end

   // serializer states, gray along idle to send
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01
   } ser_state_t;

   // pin synchronisers
   logic clk_s1_r;     // sample clock, first stage
   logic clk_s2_r;     // sample clock, second stage
   logic clk_s3_r;     // previous synchronised level
   logic odm_s1_r;     // output-mode pin, first stage
   logic odm_s2_r;     // output-mode pin, second stage
   logic clk_s1_nxt;
   logic clk_s2_nxt;
   logic clk_s3_nxt;
   logic odm_s1_nxt;
   logic odm_s2_nxt;
   logic sample_edge;  // rising edge of the sample clock

   // next values of the synchronisers
   always_comb begin
      clk_s1_nxt  = sample_clk_pin;
      clk_s2_nxt  = clk_s1_r;
      clk_s3_nxt  = clk_s2_r;
      odm_s1_nxt  = serial_io_output_mode_pin;
      odm_s2_nxt  = odm_s1_r;
      sample_edge = clk_s2_r & ~clk_s3_r;
   end

   // synchroniser registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         clk_s1_r <= 1'b0;
         clk_s2_r <= 1'b0;
         clk_s3_r <= 1'b0;
         odm_s1_r <= 1'b0;
         odm_s2_r <= 1'b0;
      end else if (ce) begin
         clk_s1_r <= clk_s1_nxt;
         clk_s2_r <= clk_s2_nxt;
         clk_s3_r <= clk_s3_nxt;
         odm_s1_r <= odm_s1_nxt;
         odm_s2_r <= odm_s2_nxt;
      end
   end

   // user pattern registers
   logic [7:0] one_low_r;     // user word one, low byte
   logic [7:0] one_high_r;    // user word one, high byte
   logic [7:0] two_low_r;     // user word two, low byte
   logic [7:0] two_high_r;    // user word two, high byte
   logic [7:0] one_low_nxt;
   logic [7:0] one_high_nxt;
   logic [7:0] two_low_nxt;
   logic [7:0] two_high_nxt;
   logic [7:0] rdata_nxt;

   // write decode and read mux
   always_comb begin
      one_low_nxt  = one_low_r;
      one_high_nxt = one_high_r;
      two_low_nxt  = two_low_r;
      two_high_nxt = two_high_r;
      if (reg_wr_en) begin
         case (reg_addr)
            fmt_pkg::REG_USER_ONE_LOW:  one_low_nxt  = reg_wdata;
            fmt_pkg::REG_USER_ONE_HIGH: one_high_nxt = reg_wdata;
            fmt_pkg::REG_USER_TWO_LOW:  two_low_nxt  = reg_wdata;
            fmt_pkg::REG_USER_TWO_HIGH: two_high_nxt = reg_wdata;
            default:                    one_low_nxt  = one_low_r;
         endcase
      end
      // unmapped addresses read zero
      case (reg_addr)
         fmt_pkg::REG_USER_ONE_LOW:  rdata_nxt = one_low_r;
         fmt_pkg::REG_USER_ONE_HIGH: rdata_nxt = one_high_r;
         fmt_pkg::REG_USER_TWO_LOW:  rdata_nxt = two_low_r;
         fmt_pkg::REG_USER_TWO_HIGH: rdata_nxt = two_high_r;
         default:                    rdata_nxt = 8'h00;
      endcase
   end

   // register file
   always_ff @(posedge core_clk) begin
      if (rst) begin
         one_low_r  <= fmt_pkg::REG_RESET;
         one_high_r <= fmt_pkg::REG_RESET;
         two_low_r  <= fmt_pkg::REG_RESET;
         two_high_r <= fmt_pkg::REG_RESET;
         reg_rdata  <= 8'h00;
      end else if (ce) begin
         one_low_r  <= one_low_nxt;
         one_high_r <= one_high_nxt;
         two_low_r  <= two_low_nxt;
         two_high_r <= two_high_nxt;
         reg_rdata  <= rdata_nxt;
      end
   end

   // word builders, one per lane
   logic [LANES-1:0][13:0] built;   // candidate word per lane
   logic                   phase_r; // alternating-word phase, 0 = word one
   logic                   pn_bit;  // pseudorandom bit shared by lanes
   logic                   pn_mode; // a pseudorandom mode is selected
   ser_state_t             state_r;

   // same pattern source on every lane, only data differs
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      test_word_build u_build (
         .cfg      (cfg),
         .phase    (phase_r),
         .user_one ({one_high_r, one_low_r}),
         .user_two ({two_high_r, two_low_r}),
         .sample   (samples.ch[i]),
         .word     (built[i])
      );
   end

   assign pn_mode = (cfg.test_mode == fmt_pkg::TM_PN_LONG)
                  | (cfg.test_mode == fmt_pkg::TM_PN_SHORT);

   // pseudorandom stream steps once per bit sent
   pn_bit_source u_pn (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .step     (state_r == ST_SEND),
      .long_sel (cfg.test_mode == fmt_pkg::TM_PN_LONG),
      .reseed   (!pn_mode),
      .pn_bit   (pn_bit)
   );

   // serializer
   logic [fmt_pkg::CNT_W-1:0] cnt_r;     // bits sent in this word
   logic [fmt_pkg::CNT_W-1:0] len_r;     // word length in bits
   logic                      lsb_r;     // bit order of this word
   logic                      pend_r;    // sample edge waiting for a frame
   logic [LANES-1:0][13:0]    word_r;    // words in flight
   ser_state_t                state_nxt;
   logic [fmt_pkg::CNT_W-1:0] cnt_nxt;
   logic [fmt_pkg::CNT_W-1:0] len_nxt;
   logic                      lsb_nxt;
   logic                      pend_nxt;
   logic                      phase_nxt;
   logic [LANES-1:0][13:0]    word_nxt;
   logic [LANES-1:0]          lanes_nxt;
   logic                      bclk_nxt;
   logic                      fclk_nxt;
   logic [fmt_pkg::CNT_W-1:0] new_len;   // length chosen by config
   logic [fmt_pkg::CNT_W-1:0] pos;       // bit index into the word
   logic                      start;     // load a new frame

   // frame sequencing, bit selection and output clocks
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      len_nxt   = len_r;
      lsb_nxt   = lsb_r;
      pend_nxt  = pend_r | sample_edge;
      phase_nxt = phase_r;
      word_nxt  = word_r;
      start     = 1'b0;
      // shorter or longer serial words
      case (cfg.word_len)
         fmt_pkg::WL_8:  new_len = 4'd8;
         fmt_pkg::WL_10: new_len = 4'd10;
         fmt_pkg::WL_14: new_len = 4'd14;
         default:        new_len = 4'd12;
      endcase
      case (state_r)
         ST_IDLE: begin
            // wait for the next sample clock
            if (pend_r | sample_edge) begin
               start = 1'b1;
            end
         end
         ST_SEND: begin
            if (cnt_r == len_r - 4'd1) begin
               // word done: chain straight on if a sample waits
               if (pend_r | sample_edge) begin
                  start = 1'b1;
               end else begin
                  state_nxt = ST_IDLE;
               end
            end else begin
               cnt_nxt = cnt_r + 4'd1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      // words load only at a frame boundary, all lanes together
      if (start) begin
         state_nxt = ST_SEND;
         cnt_nxt   = '0;
         len_nxt   = new_len;
         lsb_nxt   = cfg.lsb_first;
         pend_nxt  = 1'b0;
         phase_nxt = ~phase_r;
         word_nxt  = built;
      end
      // msb sits at bit 13; lsb of an n-bit word at 14 - n
      if (lsb_r) begin
         pos = 4'd14 - len_r + cnt_r;
      end else begin
         pos = 4'd13 - cnt_r;
      end
      // one bit per bit-clock edge
      for (int i = 0; i < LANES; i++) begin
         if (state_r != ST_SEND) begin
            lanes_nxt[i] = 1'b0;
         end else if (pn_mode) begin
            lanes_nxt[i] = pn_bit;
         end else begin
            lanes_nxt[i] = word_r[i][pos];
         end
      end
      // bit clock toggles every bit: six cycles per 12-bit word
      bclk_nxt = (state_r == ST_SEND) ? ~data_bit_clock_out : 1'b0;
      // frame clock high over the first half of each word
      fclk_nxt = (state_r == ST_SEND) && (cnt_r < (len_r >> 1));
   end

   // serializer registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r            <= ST_IDLE;
         cnt_r              <= '0;
         len_r              <= 4'd12;
         lsb_r              <= 1'b0;
         pend_r             <= 1'b0;
         phase_r            <= 1'b0;
         word_r             <= '0;
         data_lanes_out     <= '0;
         data_bit_clock_out <= 1'b0;
         frame_clock_out    <= 1'b0;
      end else if (ce) begin
         state_r            <= state_nxt;
         cnt_r              <= cnt_nxt;
         len_r              <= len_nxt;
         lsb_r              <= lsb_nxt;
         pend_r             <= pend_nxt;
         phase_r            <= phase_nxt;
         word_r             <= word_nxt;
         data_lanes_out     <= lanes_nxt;
         data_bit_clock_out <= bclk_nxt;
         frame_clock_out    <= fclk_nxt;
      end
   end

   // output driver controls
   logic swing_nxt;
   logic drive_nxt;
   logic pll_nxt;

   // driver mode decode
   always_comb begin
      swing_nxt = odm_s2_r | cfg.low_swing;
      drive_nxt = cfg.clk_drive_double & (cfg.term_sel == 2'b00);
      pll_nxt   = cfg.low_rate_pll;
   end

   // driver control registers, full lvds swing after reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reduced_swing_out    <= 1'b0;
         clk_drive_double_out <= 1'b0;
         pll_low_rate_out     <= 1'b0;
      end else if (ce) begin
         reduced_swing_out    <= swing_nxt;
         clk_drive_double_out <= drive_nxt;
         pll_low_rate_out     <= pll_nxt;
      end
   end
endmodule
`default_nettype wire

// File: tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic              core_clk, rst, ce, mode_pin, run, wr_en; // stimulus
   logic [7:0]        addr, wdata, rdata;    // register port
   logic [3:0]        len;                   // word length for receiver
   logic [7:0]        lanes;                 // serial lanes
   logic              bclk, fclk, sample_pin; // link clocks
   logic              swing, ddrive, pll_low; // static outputs
   fmt_pkg::cfg_t     cfg;                   // configuration
   fmt_pkg::samples_t samples;               // converter data
   logic [7:0][13:0]  word, prev;            // last two words received
   int                words, err_total, check_count; // tallies

   serial_adc_output_formatter u_serial_adc_output_formatter (.core_clk(core_clk), .rst(rst),
      .ce(ce), .sample_clk_pin(sample_pin), .serial_io_output_mode_pin(mode_pin), .cfg(cfg),
      .samples(samples), .reg_wr_en(wr_en), .reg_addr(addr), .reg_wdata(wdata),
      .reg_rdata(rdata), .data_lanes_out(lanes), .data_bit_clock_out(bclk),
      .frame_clock_out(fclk), .reduced_swing_out(swing), .clk_drive_double_out(ddrive),
      .pll_low_rate_out(pll_low));
   fmt_receiver u_fmt_receiver (.core_clk(core_clk), .run(run), .len(len), .lanes(lanes),
      .bclk(bclk), .fclk(fclk), .sample_pin(sample_pin), .word(word), .prev(prev),
      .words(words));

   // 10 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic tick(int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask

   task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %s exp %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // expected serial word of a 12-bit value at n bits
   function automatic logic [13:0] exp_word(logic [11:0] s, int n, logic lsb);
      logic [13:0] w, r;
      w = {s, 2'b00} >> (14 - n);
      r = '0;
      for (int j = 0; j < n; j++) r[j] = w[n-1-j];
      return lsb ? r : w;
   endfunction

   // let k words arrive, then let the stream drain
   task automatic get_words(int k);
      int start = words;
      int guard = 0;
      run = 1'b1;
      while (words < start + k && guard < 2000) begin
         tick(1);
         guard++;
      end
      run = 1'b0;
      check("word arrival", guard < 2000, 1'b1);
      tick(40);
   endtask

   task automatic t_regs;
      logic [7:0] a [5] = '{8'h1d, 8'h19, 8'h1a, 8'h1b, 8'h1c};
      logic [7:0] v [5] = '{8'h77, 8'h50, 8'hc3, 8'ha0, 8'h3f};
      for (int i = 0; i < 5; i++) begin
         addr = a[i];
         tick(1);
         check("reg reset", rdata, 8'h00);
      end
      wr_en = 1'b1;
      for (int i = 0; i < 5; i++) begin
         addr = a[i];
         wdata = v[i];
         tick(1);
      end
      wr_en = 1'b0;
      tick(1);
      for (int i = 0; i < 5; i++) begin
         addr = a[i];
         tick(1);
         check("reg readback", rdata, i == 0 ? 8'h00 : v[i]);
      end
      $display("t_regs done");
   endtask

   task automatic t_static;
      for (int i = 0; i < 32; i++) begin
         {mode_pin, cfg.low_swing, cfg.clk_drive_double, cfg.term_sel} = 5'(i);
         cfg.low_rate_pll = i[0];
         tick(5);
         check("swing", swing, mode_pin | cfg.low_swing);
         check("drive", ddrive, cfg.clk_drive_double & (cfg.term_sel == 2'h0));
         check("pll", pll_low, cfg.low_rate_pll);
      end
      mode_pin = 1'b0;
      cfg = '0;
      $display("t_static done");
   endtask

   task automatic t_data;
      logic [11:0] s;
      for (int f = 0; f < 2; f++) begin
         cfg = '0;
         cfg.twos_comp = f[0];
         len = 4'hc;
         get_words(3);
         for (int i = 0; i < 8; i++) begin
            s = samples.ch[i];
            check("data", word[i], exp_word({s[11] ^ f[0], s[10:0]}, 12, 1'b0));
         end
      end
      $display("t_data done");
   endtask

   task automatic t_len;
      int lens [4] = '{12, 8, 10, 14};
      for (int k = 0; k < 8; k++) begin
         cfg = '0;
         cfg.word_len = 2'(k);
         cfg.lsb_first = k[2];
         len = 4'(lens[k % 4]);
         get_words(3);
         for (int i = 0; i < 8; i++) begin
            check("order", word[i], exp_word(samples.ch[i], len, k[2]));
         end
      end
      $display("t_len done");
   endtask

   task automatic t_pattern;
      logic [31:0] rows [13] = '{32'h01800800, 32'h11000000, 32'h02ffffff, 32'h13800800,
         32'h14aaa555, 32'h17fff000, 32'h18c353fa, 32'h19aaaaaa, 32'h1a03f03f,
         32'h1b800800, 32'h1ca33a33, 32'h05000000, 32'h06000000};
      logic [23:0] pair;
      for (int r = 0; r < 13; r++) begin
         cfg = '0;
         cfg.twos_comp = rows[r][28];
         cfg.test_mode = fmt_pkg::test_mode_t'(rows[r][27:24]);
         len = 4'hc;
         get_words(3);
         pair = {prev[0][11:0], word[0][11:0]};
         if (!(rows[r][27:24] inside {4'h5, 4'h6})) begin
            check("pattern", pair, prev[0][11:0] === rows[r][23:12] ? rows[r][23:0] :
               {rows[r][11:0], rows[r][23:12]});
         end
         check("lane match", word[7], word[0]);
      end
      $display("t_pattern done");
   endtask

   // tests take a few thousand cycles
   initial begin
      repeat (30000) @(posedge core_clk);
      err_total++;
      end_of_test();
   end

   initial begin
      {rst, ce, mode_pin, run, wr_en} = 5'b11000;
      {addr, wdata, len, cfg} = '0;
      samples.ch = {12'hfff, 12'h800, 12'h7ff, 12'h000, 12'h5a3, 12'h0c1, 12'hf0e, 12'h3b7};
      err_total = 0;
      check_count = 0;
      tick(10);
      rst = 1'b0;
      t_regs();
      t_static();
      t_data();
      t_len();
      t_pattern();
      end_of_test();
   end
endmodule
`default_nettype wire

// File: test_word_build.sv
`default_nettype none
module test_word_build (
   input  wire fmt_pkg::cfg_t cfg,
   input  wire logic          phase,
   input  wire logic [15:0]   user_one,
   input  wire logic [15:0]   user_two,
   input  wire logic [11:0]   sample,
   output var  logic [13:0]   word
);
   logic [13:0] mask;   // left-aligned ones of word length
   logic [13:0] mix;    // mixed-frequency word, right aligned
   logic [3:0]  sh;     // left shift for alignment

   // build a left-aligned word; bit 13 is sent first in msb order
   always_comb begin
      case (cfg.word_len)
         fmt_pkg::WL_8:  begin sh = 4'd6; mix = fmt_pkg::MIX_8;  end
         fmt_pkg::WL_10: begin sh = 4'd4; mix = fmt_pkg::MIX_10; end
         fmt_pkg::WL_14: begin sh = 4'd0; mix = fmt_pkg::MIX_14; end
         default:        begin sh = 4'd2; mix = fmt_pkg::MIX_12; end
      endcase
      mask = 14'h3fff << sh;
      case (cfg.test_mode)
         fmt_pkg::TM_MID:      word = 14'h2000;
         fmt_pkg::TM_POS:      word = mask;
         fmt_pkg::TM_NEG:      word = 14'h0000;
         fmt_pkg::TM_CHECK:    word = (phase ? 14'h1555 : 14'h2aaa) & mask;
         fmt_pkg::TM_WORD_TOG: word = phase ? 14'h0000 : mask;
         fmt_pkg::TM_USER:     word = (phase ? user_two[15:2] : user_one[15:2]) & mask;
         fmt_pkg::TM_BIT_TOG:  word = 14'h2aaa & mask;
         fmt_pkg::TM_ONE_HIGH: word = 14'h2000;
         fmt_pkg::TM_SYNC:     word = (14'h3fff >> (4'he - ((4'he - sh) >> 1))) << sh;
         fmt_pkg::TM_MIXED:    word = mix << sh;
         default:              word = {sample, 2'b00};
      endcase
      // format select flips the sign bit for data and scale patterns
      if (cfg.twos_comp && (cfg.test_mode <= fmt_pkg::TM_NEG)) begin
         word[13] = ~word[13];
      end
   end
endmodule
`default_nettype wire
